/* src/ncb_pkg.sv */
// Purpose: shared constants and types for the channel B oscillator
//          preset bank and startup status.
// Assumes: byte-addressed serial control port with 15-bit addresses.
// Notes:   multi-byte words sit least significant byte first.
package ncb_pkg;
   localparam int          ADDR_W          = 15;
   localparam int          HDR_BITS        = 16;
   localparam int          RW_BIT          = 15;
   localparam int          BYTE_BITS       = 8;
   localparam logic [14:0] ADDR_SOFT_RESET = 15'h0000;
   localparam logic [14:0] ADDR_PHASE_P1   = 15'h024c;
   localparam logic [14:0] ADDR_FREQ_P2    = 15'h0250;
   localparam logic [14:0] ADDR_PHASE_P2   = 15'h0254;
   localparam logic [14:0] ADDR_FREQ_P3    = 15'h0258;
   localparam logic [14:0] ADDR_PHASE_P3   = 15'h025c;
   localparam logic [14:0] ADDR_STARTUP    = 15'h0270;
   localparam logic [14:0] ADDR_REVISION   = 15'h0297;
   localparam logic [15:0] PHASE_RST       = 16'h0000;
   localparam logic [31:0] FREQ_RST        = 32'hc0000000;
   localparam int          SOFT_RESET_BIT  = 0;
   localparam int          INIT_DONE_BIT   = 0;
   localparam int          REV_FIELD_W     = 5;
   // arbitrary value, not a real part code
   localparam logic [4:0]  REV_CODE_DEF    = 5'h15;
   localparam int          INIT_CYCLES_DEF = 64;

   typedef enum logic [1:0] {
      SPI_IDLE,
      SPI_HEADER,
      SPI_WRITE,
      SPI_READ
   } ncb_spi_state_t;
endpackage

/* src/ncb_sync2.sv */
// Purpose: two-flop synchroniser for pin inputs.
// Assumes: inputs are asynchronous to i_core_clk.
// Notes:   only the second stage is visible outside.
`timescale 1ns/1ps
module ncb_sync2 #(
   parameter int         WIDTH = 1,
   parameter logic [0:0] RST_V = 1'b0
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_reset,
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         meta_q <= {WIDTH{RST_V}};
         o_q    <= {WIDTH{RST_V}};
      end
      else
      begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule

/* src/ncb_bank.sv */
// Function
// - preset 1 phase word, 16 bits read/write, resets to zero.
// - preset 2 frequency word, 32 bits read/write, resets to 0xc0000000.
// - preset 2 phase word, 16 bits read/write, resets to zero.
// - preset 3 frequency word, 32 bits read/write, resets to 0xc0000000.
// - preset 3 phase word, 16 bits read/write, resets to zero.
// - status bit 0 reads 1 once startup initialization has finished.
// - status bits 7 to 1 are reserved and read-only.
// - interleaved mode ignores all channel B settings, using channel A; the bank drives all channel B outputs to zero instead.
//
// Purpose: channel B oscillator preset bank behind the serial port.
// Assumes: spi mode 0, csb active low, sclk low for at least 4 core clocks.
// Notes:   words update byte by byte as each byte completes.
`timescale 1ns/1ps
module ncb_bank
   import ncb_pkg::*;
#(
   parameter int         INIT_CYCLES = INIT_CYCLES_DEF,
   parameter logic [4:0] REV_CODE    = REV_CODE_DEF
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic        i_spi_sclk,
   input  wire logic        i_spi_cs_n,
   input  wire logic        i_spi_sdi,
   input  wire logic        i_interleave_mode,
   output logic             o_spi_sdo,
   output logic             o_spi_sdo_oe_n,
   output logic             o_init_done,
   output logic [15:0]      o_chb_phase_p1,
   output logic [31:0]      o_chb_freq_p2,
   output logic [15:0]      o_chb_phase_p2,
   output logic [31:0]      o_chb_freq_p3,
   output logic [15:0]      o_chb_phase_p3
);
   logic                sclk_s;
   logic                cs_n_s;
   logic                sdi_s;
   logic                sclk_prev_q;
   logic                rise;
   logic                fall;
   ncb_spi_state_t      state_q;
   logic [4:0]          cnt_q;
   logic [15:0]         shift_q;
   logic [15:0]         hdr_next;
   logic [14:0]         addr_q;
   logic [14:0]         rd_addr;
   logic [7:0]          rd_byte;
   logic [7:0]          tx_q;
   logic                sdo_q;
   logic                oe_n_q;
   logic                wr_stb_q;
   logic [14:0]         wr_addr_q;
   logic [7:0]          wr_data_q;
   logic                soft_rst_q;
   logic                bank_rst;
   logic [15:0]         phase_p1_q;
   logic [31:0]         freq_p2_q;
   logic [15:0]         phase_p2_q;
   logic [31:0]         freq_p3_q;
   logic [15:0]         phase_p3_q;
   logic [31:0]         init_cnt_q;
   logic                init_done_q;

   function automatic logic [31:0] put32(input logic [31:0] old,
                                         input logic [1:0]  lane,
                                         input logic [7:0]  data);
      logic [31:0] r;
      r = old;
      r[lane*8 +: 8] = data;
      return r;
   endfunction

   function automatic logic [15:0] put16(input logic [15:0] old,
                                         input logic [1:0]  lane,
                                         input logic [7:0]  data);
      logic [15:0] r;
      r = old;
      if (lane == 2'h0)
         r[7:0] = data;
      else if (lane == 2'h1)
         r[15:8] = data;
      return r;
   endfunction

   function automatic logic [7:0] get8(input logic [31:0] word,
                                       input logic [1:0]  lane);
      return word[lane*8 +: 8];
   endfunction

   ncb_sync2 #(
      .WIDTH (1),
      .RST_V (1'b0)
   ) u_sync_sclk (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_d        (i_spi_sclk),
      .o_q        (sclk_s)
   );

   ncb_sync2 #(
      .WIDTH (1),
      .RST_V (1'b1)
   ) u_sync_cs (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_d        (i_spi_cs_n),
      .o_q        (cs_n_s)
   );

   ncb_sync2 #(
      .WIDTH (1),
      .RST_V (1'b0)
   ) u_sync_sdi (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_d        (i_spi_sdi),
      .o_q        (sdi_s)
   );

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         sclk_prev_q <= 1'b0;
      else
         sclk_prev_q <= sclk_s;
   end

   assign rise     = sclk_s & ~sclk_prev_q & ~cs_n_s;
   assign fall     = ~sclk_s & sclk_prev_q & ~cs_n_s;
   assign hdr_next = {shift_q[14:0], sdi_s};
   assign bank_rst = i_reset | soft_rst_q;

   // header completion reads from the fresh address, later bytes stream
   assign rd_addr = (state_q == SPI_HEADER) ? hdr_next[14:0] : addr_q;

   always_comb
   begin
      rd_byte = 8'h00;
      unique case ({rd_addr[14:2], 2'b00})
         ADDR_PHASE_P1: rd_byte = get8({16'h0000, phase_p1_q}, rd_addr[1:0]);
         ADDR_FREQ_P2:  rd_byte = get8(freq_p2_q, rd_addr[1:0]);
         ADDR_PHASE_P2: rd_byte = get8({16'h0000, phase_p2_q}, rd_addr[1:0]);
         ADDR_FREQ_P3:  rd_byte = get8(freq_p3_q, rd_addr[1:0]);
         ADDR_PHASE_P3: rd_byte = get8({16'h0000, phase_p3_q}, rd_addr[1:0]);
         default:       rd_byte = 8'h00;
      endcase
      if (rd_addr == ADDR_STARTUP)
         rd_byte = {7'h00, init_done_q};
      else if (rd_addr == ADDR_REVISION)
         rd_byte = {3'h0, REV_CODE};
   end

   // frame engine: 16-bit header (read flag, address), then data bytes
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset || cs_n_s)
      begin
         state_q <= SPI_IDLE;
         cnt_q   <= 5'h00;
         shift_q <= 16'h0000;
         addr_q  <= 15'h0000;
         tx_q    <= 8'h00;
      end
      else if (state_q == SPI_IDLE)
      begin
         state_q <= SPI_HEADER;
         cnt_q   <= 5'h00;
      end
      else if (rise)
      begin
         shift_q <= hdr_next;
         unique case (state_q)
            SPI_HEADER:
            begin
               if (cnt_q == 5'(HDR_BITS - 1))
               begin
                  cnt_q  <= 5'h00;
                  addr_q <= 15'(hdr_next[14:0] + 15'h0001);
                  if (hdr_next[RW_BIT])
                  begin
                     state_q <= SPI_READ;
                     tx_q    <= rd_byte;
                  end
                  else
                  begin
                     state_q <= SPI_WRITE;
                     addr_q  <= hdr_next[14:0];
                  end
               end
               else
                  cnt_q <= 5'(cnt_q + 5'h01);
            end
            SPI_WRITE, SPI_READ:
            begin
               if (cnt_q == 5'(BYTE_BITS - 1))
               begin
                  cnt_q  <= 5'h00;
                  addr_q <= 15'(addr_q + 15'h0001);
                  if (state_q == SPI_READ)
                     tx_q <= rd_byte;
               end
               else
                  cnt_q <= 5'(cnt_q + 5'h01);
            end
            SPI_IDLE:
               cnt_q <= 5'h00;
         endcase
      end
      else if (fall && state_q == SPI_READ)
         tx_q <= {tx_q[6:0], 1'b0};
   end

   // write strobe, one core cycle per completed data byte
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         wr_stb_q  <= 1'b0;
         wr_addr_q <= 15'h0000;
         wr_data_q <= 8'h00;
      end
      else
      begin
         wr_stb_q <= rise && state_q == SPI_WRITE && !cs_n_s
                     && cnt_q == 5'(BYTE_BITS - 1);
         if (rise && state_q == SPI_WRITE)
         begin
            wr_addr_q <= addr_q;
            wr_data_q <= hdr_next[7:0];
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
         soft_rst_q <= 1'b0;
      else
         soft_rst_q <= wr_stb_q && wr_addr_q == ADDR_SOFT_RESET
                       && wr_data_q[SOFT_RESET_BIT];
   end

   always_ff @(posedge i_core_clk)
   begin
      if (bank_rst)
      begin
         phase_p1_q <= PHASE_RST;
         freq_p2_q  <= FREQ_RST;
         phase_p2_q <= PHASE_RST;
         freq_p3_q  <= FREQ_RST;
         phase_p3_q <= PHASE_RST;
      end
      else if (wr_stb_q)
      begin
         unique case ({wr_addr_q[14:2], 2'b00})
            ADDR_PHASE_P1:
               phase_p1_q <= put16(phase_p1_q, wr_addr_q[1:0], wr_data_q);
            ADDR_FREQ_P2:
               freq_p2_q <= put32(freq_p2_q, wr_addr_q[1:0], wr_data_q);
            ADDR_PHASE_P2:
               phase_p2_q <= put16(phase_p2_q, wr_addr_q[1:0], wr_data_q);
            ADDR_FREQ_P3:
               freq_p3_q <= put32(freq_p3_q, wr_addr_q[1:0], wr_data_q);
            ADDR_PHASE_P3:
               phase_p3_q <= put16(phase_p3_q, wr_addr_q[1:0], wr_data_q);
            default:
               phase_p1_q <= phase_p1_q;
         endcase
      end
   end

   // startup sequence restarts on either reset; no access is blocked,
   // the host is trusted to wait for done
   always_ff @(posedge i_core_clk)
   begin
      if (bank_rst)
      begin
         init_cnt_q  <= 32'h00000000;
         init_done_q <= 1'b0;
      end
      else if (!init_done_q)
      begin
         init_cnt_q <= 32'(init_cnt_q + 32'h00000001);
         if (init_cnt_q >= 32'(INIT_CYCLES - 1))
            init_done_q <= 1'b1;
      end
   end

   // datapath view of channel B; zero while interleaved
   always_ff @(posedge i_core_clk)
   begin
      if (i_reset || i_interleave_mode)
      begin
         o_chb_phase_p1 <= 16'h0000;
         o_chb_freq_p2  <= 32'h00000000;
         o_chb_phase_p2 <= 16'h0000;
         o_chb_freq_p3  <= 32'h00000000;
         o_chb_phase_p3 <= 16'h0000;
      end
      else
      begin
         o_chb_phase_p1 <= phase_p1_q;
         o_chb_freq_p2  <= freq_p2_q;
         o_chb_phase_p2 <= phase_p2_q;
         o_chb_freq_p3  <= freq_p3_q;
         o_chb_phase_p3 <= phase_p3_q;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_reset)
      begin
         sdo_q  <= 1'b0;
         oe_n_q <= 1'b1;
      end
      else
      begin
         // launch and shift share one fall, so bit 7 is not skipped
         if (fall && state_q == SPI_READ)
            sdo_q <= tx_q[7];
         oe_n_q <= !(state_q == SPI_READ && !cs_n_s);
      end
   end

   assign o_spi_sdo      = sdo_q;
   assign o_spi_sdo_oe_n = oe_n_q;
   assign o_init_done    = init_done_q;
endmodule

/* bench/ncb_bank_asserts.sv */
// Purpose: port checks for ncb_bank.
// Assumes: sees only the top ports.
// Notes:   bound to every ncb_bank instance.
`timescale 1ns/1ps
module ncb_bank_asserts
   import ncb_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
   input wire logic        i_core_clk,
   input wire logic        i_reset,
   input wire logic        i_spi_sclk,
   input wire logic        i_spi_cs_n,
   input wire logic        i_spi_sdi,
   input wire logic        i_interleave_mode,
   input wire logic        o_spi_sdo,
   input wire logic        o_spi_sdo_oe_n,
   input wire logic        o_init_done,
   input wire logic [15:0] o_chb_phase_p1,
   input wire logic [31:0] o_chb_freq_p2,
   input wire logic [15:0] o_chb_phase_p2,
   input wire logic [31:0] o_chb_freq_p3,
   input wire logic [15:0] o_chb_phase_p3
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   a_reset_quiet: assert property (disable iff (1'b0)
      i_reset |=> o_spi_sdo_oe_n && !o_spi_sdo && !o_init_done)
      else $error("outputs not quiet in reset");
   a_reset_values: assert property (
      $fell(i_reset) && !i_interleave_mode |-> ##2
      (o_chb_freq_p3 == FREQ_RST && o_chb_phase_p3 == PHASE_RST))
      else $error("bank not at reset values");
   a_init_wait: assert property (
      $fell(i_reset) |-> !o_init_done [*8] ##[1:INIT_CYCLES] o_init_done)
      else $error("startup done timing wrong");
   a_done_sticky: assert property (
      $fell(o_init_done) |-> $past(i_reset) || $past(!i_spi_cs_n))
      else $error("startup done dropped outside a reset");
   a_interleave_zero: assert property (
      i_interleave_mode |=> o_chb_freq_p2 == '0 && o_chb_freq_p3 == '0
      && o_chb_phase_p1 == '0 && o_chb_phase_p2 == '0
      && o_chb_phase_p3 == '0)
      else $error("channel B outputs not gated");
   a_idle_release: assert property (
      i_spi_cs_n [*5] |-> o_spi_sdo_oe_n)
      else $error("data out driven while deselected");
   a_oe_needs_cs: assert property (
      $fell(o_spi_sdo_oe_n) |-> !i_spi_cs_n)
      else $error("data out enabled without select");
   a_outs_stable: assert property (
      (i_spi_cs_n && !i_interleave_mode) [*8] |->
      $stable(o_chb_freq_p2) && $stable(o_chb_phase_p1))
      else $error("bank changed with no access");
endmodule

bind ncb_bank ncb_bank_asserts #(.INIT_CYCLES(INIT_CYCLES))
   u_ncb_bank_asserts (.*);

/* bench/ncb_host.sv */
// Purpose: serial port host model, mode 0, msb first.
// Assumes: pins change only on core clock rising edges.
// Notes:   slow low phase so data out settles before sampling.
`timescale 1ns/1ps
module ncb_host (
   input  wire logic i_core_clk,
   input  wire logic i_sdo,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_sdi
);
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi  = 1'b0;
   end

   // low 7 cycles: data out lags the pin fall by 3
   task automatic bit_io(input logic b, output logic r);
      @(posedge i_core_clk) o_sdi <= b;
      repeat (6) @(posedge i_core_clk);
      r = i_sdo;
      o_sclk <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      o_sclk <= 1'b0;
   endtask

   // bytes go least significant first, bits msb first
   task automatic xfer(input logic [15:0] hdr, input int nb,
                       input logic [31:0] wd, output logic [31:0] rd);
      logic r;
      rd = '0;
      @(posedge i_core_clk) o_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--)
         bit_io(hdr[i], r);
      for (int k = 0; k < nb; k++)
         for (int i = 7; i >= 0; i--)
         begin
            bit_io(wd[8*k+i], r);
            rd[8*k+i] = r;
         end
      repeat (3) @(posedge i_core_clk);
      o_cs_n <= 1'b1;
      // released line must not keep its last value
      o_sdi  <= ~o_sdi;
      repeat (4) @(posedge i_core_clk);
   endtask
endmodule

/* bench/ncb_bank_tb.sv */
// Purpose: self-checking bench for ncb_bank.
// Assumes: host model drives the serial pins.
// Notes:   short startup count keeps the run brief.
`timescale 1ns/1ps
module ncb_bank_tb;
   import ncb_pkg::*;
   localparam int INIT_N = 40;
   typedef struct packed {
      logic [14:0] a;
      logic [2:0]  n;
      logic [31:0] d;
   } ncb_row_t;
   logic        clk;
   logic        rst;
   logic        ilv;
   logic        sclk, cs_n, sdi, sdo, oe_n, done;
   logic [15:0] p1, p2, p3;
   logic [31:0] f2, f3, rd;
   int          errors;
   int          checked;
   ncb_row_t    rows [5] = '{
      '{ADDR_PHASE_P1, 3'h2, 32'h0000a5c3},
      '{ADDR_FREQ_P2,  3'h4, 32'h12345678},
      '{ADDR_PHASE_P2, 3'h2, 32'h0000ffff},
      '{ADDR_FREQ_P3,  3'h4, 32'hdeadbeef},
      '{ADDR_PHASE_P3, 3'h2, 32'h00000001}};

   ncb_bank #(.INIT_CYCLES(INIT_N)) u_ncb_bank (
      .i_core_clk(clk), .i_reset(rst), .i_spi_sclk(sclk),
      .i_spi_cs_n(cs_n), .i_spi_sdi(sdi), .i_interleave_mode(ilv),
      .o_spi_sdo(sdo), .o_spi_sdo_oe_n(oe_n), .o_init_done(done),
      .o_chb_phase_p1(p1), .o_chb_freq_p2(f2), .o_chb_phase_p2(p2),
      .o_chb_freq_p3(f3), .o_chb_phase_p3(p3));
   ncb_host u_ncb_host (.i_core_clk(clk), .i_sdo(sdo), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_sdi(sdi));

   function automatic logic [31:0] port_of(input logic [14:0] a);
      case (a)
         ADDR_PHASE_P1: port_of = {16'h0000, p1};
         ADDR_FREQ_P2:  port_of = f2;
         ADDR_PHASE_P2: port_of = {16'h0000, p2};
         ADDR_PHASE_P3: port_of = {16'h0000, p3};
         default:       port_of = f3;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("checks=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wait_done(input logic v);
      int n;
      n = 0;
      while (done !== v && n < 80)
      begin
         @(posedge clk);
         n++;
      end
      if (done !== v)
      begin
         errors++;
         results();
      end
   endtask

   task automatic acc(input logic rw, input logic [14:0] a,
                      input int nb, input logic [31:0] d);
      u_ncb_host.xfer({rw, a}, nb, d, rd);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      errors  = 0;
      checked = 0;
      rst     = 1'b1;
      ilv     = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk({31'h0, done}, 32'h0);
      foreach (rows[i])
         chk(port_of(rows[i].a), rows[i].n == 3'h4 ? FREQ_RST : 32'h0);
      wait_done(1'b1);
      acc(1'b1, ADDR_STARTUP, 1, 32'h0);
      chk(rd, 32'h1);
      foreach (rows[i])
      begin
         acc(1'b0, rows[i].a, rows[i].n, rows[i].d);
         chk(port_of(rows[i].a), rows[i].d);
         acc(1'b1, rows[i].a, rows[i].n, 32'h0);
         chk(rd, rows[i].d);
      end
      // upper lanes of a phase word are not storage
      acc(1'b0, ADDR_PHASE_P1, 4, 32'hffff1234);
      acc(1'b1, ADDR_PHASE_P1, 4, 32'h0);
      chk(rd, 32'h00001234);
      acc(1'b0, ADDR_STARTUP, 1, 32'h000000fe);
      acc(1'b1, ADDR_STARTUP, 1, 32'h0);
      chk(rd, 32'h1);
      acc(1'b1, 15'h0260, 4, 32'hffffffff);
      chk(rd, 32'h0);
      ilv <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(port_of(ADDR_FREQ_P2), 32'h0);
      chk({16'h0000, p3}, 32'h0);
      acc(1'b1, ADDR_FREQ_P2, 4, 32'h0);
      chk(rd, 32'h12345678);
      ilv <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(port_of(ADDR_FREQ_P2), 32'h12345678);
      acc(1'b0, ADDR_SOFT_RESET, 1, 32'h1);
      chk({31'h0, done}, 32'h0);
      chk(port_of(ADDR_FREQ_P2), FREQ_RST);
      chk(port_of(ADDR_PHASE_P1), PHASE_RST);
      wait_done(1'b1);
      results();
   end
endmodule
